/* File: logic/monitor_serial_params.svh */
// Purpose: constants of the monitor serial target
// Assumes: included by the top module and the bench top only
// Notes:   pointer offsets, command codes, coefficient defaults
`ifndef MONITOR_SERIAL_PARAMS_SVH
`define MONITOR_SERIAL_PARAMS_SVH

// bus address: base plus three strap bits, eight addresses 28h..2Fh
`define ADDR_BASE        7'h28
`define ADDR_STRAP_W     3

// plain variant pointer map
`define PTR_LIVE_STATUS  8'h1e
`define PTR_CAP_SWITCH_ON_V     8'h1f
`define PTR_OUT_CURRENT  8'h21
`define PTR_FEED_A_V     8'h22
`define PTR_FEED_B_V     8'h23
`define PTR_TEMPERATURE  8'h28
`define PTR_MAX          8'hff
`define PTR_RESET        8'h00
`define UNMAPPED_DATA    8'h00

// power-management variant command codes
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_COEFFICIENTS 8'h30
`define CMD_STATUS_BYTE  8'h78
`define CMD_READ_VIN     8'h88
`define CMD_READ_VCAP    8'h8a
`define CMD_READ_IOUT    8'h8c
`define CMD_READ_TEMP    8'h8d
`define CMD_REVISION     8'h98
`define CMD_READ_FEED_A  8'hd3
`define CMD_READ_FEED_B  8'hd4
`define CMD_VENDOR_STAT  8'hd5

// protocol revision 1.2 in both parts of the command protocol
`define REVISION_CODE    8'h22
// status byte: communication/memory/logic fault bit position
`define CML_BIT          1
// direct-format coefficients answered by the query (arbitrary defaults)
`define COEF_COUNT       8'h05
`define COEF_M           16'h0001
`define COEF_B           16'h0000
`define COEF_R           8'h00

// live status bit positions
`define ST_ENABLE_A      0
`define ST_ENABLE_B      1
`define ST_ALARM         2
`define ST_CAP_SWITCH    4
`define ST_INRUSH        5
`define ST_OUT_ABOVE_UV  6

// pin filter: index of each pin in the filtered vector
`define PIN_COUNT        12
`define PIN_EN_A         0
`define PIN_EN_B         1
`define PIN_ALARM        2
`define PIN_CAP_SW       3
`define PIN_INRUSH       4
`define PIN_OUT_UV       5
`define PIN_STRAP_LO     6
`define PIN_VARIANT      9
`define PIN_SCL          10
`define PIN_SDA          11
`define PIN_RESET_VALUE  12'hc00
// cycles after reset release before the straps are frozen
`define STRAP_SETTLE     3'h4

`endif

/* File: logic/monitor_serial_pkg.sv */
// Purpose: types shared by the monitor serial target
// Assumes: constants come from monitor_serial_params.svh
// Notes:   types only, no logic
package monitor_serial_pkg;

  // protocol phase of the current transfer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WRITE,
    ST_READ
  } xfer_state_t;

  // the five 8-bit measurements from the analogue front end
  typedef struct packed {
    logic [7:0] cap_switch_on_v;
    logic [7:0] out_current;
    logic [7:0] feed_a_v;
    logic [7:0] feed_b_v;
    logic [7:0] temperature;
  } meas_t;

  // events seen on the bus, one cycle each; bit_val holds the last captured bit
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_fall;
    logic bit_rise;
    logic bit_val;
  } bus_evt_t;

endpackage

/* File: logic/monitor_serial_slave.sv */
// Purpose: two-wire serial target reporting monitor data and live status
// Assumes: SCL is the link clock; pins pass three-flop agreement filters
// Notes:   one design serves both variants, chosen by a strap at reset
`timescale 1ns/1ps
`include "monitor_serial_params.svh"

module monitor_serial_slave
  import monitor_serial_pkg::*;
(
  // system clock and reset
  input  wire logic         REF_CLK,
  input  wire logic         RSTN,
  // serial bus: clock pin doubles as the link clock
  input  wire logic         SCL,
  input  wire logic         SDA_IN,
  output logic              SDA_OUT,
  output logic              SDA_OE_N,
  // straps, read once after reset
  input  wire logic [2:0]   ADDR_STRAP,
  input  wire logic         PMBUS_SEL,
  // live status pins of the module
  input  wire logic         ENABLE_A,
  input  wire logic         ENABLE_B,
  input  wire logic         FEED_ALARM,
  input  wire logic         CAP_SWITCH_ON,
  input  wire logic         INRUSH_SWITCH_ON,
  input  wire logic         OUT_ABOVE_UV,
  // measurements from the front end, same clock as REF_CLK
  input  wire meas_t        MEAS,
  // fault flag readback
  output logic              CML_FAULT
);

  // ------------------------------------------------------------------
  // link domain: capture each data bit on the rising serial clock
  // ------------------------------------------------------------------
  logic scl_bit_ff;
  logic scl_tog_ff;

  // the captured bit stays put until the next rising edge, which is
  // microseconds away, so the toggle alone needs synchronising
  always_ff @(posedge SCL) begin
    if (!RSTN) begin
      scl_bit_ff <= 1'b0;
      scl_tog_ff <= 1'b0;
    end else begin
      scl_bit_ff <= SDA_IN;
      scl_tog_ff <= ~scl_tog_ff;
    end
  end

  // ------------------------------------------------------------------
  // pin filters: three flops, change accepted when second and third agree
  // ------------------------------------------------------------------
  logic [`PIN_COUNT-1:0] pin_raw;
  logic [`PIN_COUNT-1:0] pin_q;
  localparam logic [`PIN_COUNT-1:0] pin_init = `PIN_RESET_VALUE;
  logic [2:0]            tog_sync_ff;
  logic                  tog_seen_ff;

  assign pin_raw = {SDA_IN, SCL, PMBUS_SEL, ADDR_STRAP, OUT_ABOVE_UV,
                    INRUSH_SWITCH_ON, CAP_SWITCH_ON, FEED_ALARM,
                    ENABLE_B, ENABLE_A};

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pin
      logic [2:0] sync_ff;
      logic       q_ff;
      // stages run through reset, so the true level is known at release
      // and no false edge or stale strap follows it
      always_ff @(posedge REF_CLK) begin
        sync_ff <= {sync_ff[1:0], pin_raw[gi]};
      end
      // a single glitchy sample cannot flip the accepted level
      always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
          q_ff <= pin_init[gi];
        end else if (sync_ff[1] == sync_ff[2]) begin
          q_ff <= sync_ff[2];
        end
      end
      assign pin_q[gi] = q_ff;
    end
  endgenerate

  // toggle from the link domain; only the 2nd/3rd stages are compared
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      tog_sync_ff <= 3'h0;
      tog_seen_ff <= 1'b0;
    end else begin
      tog_sync_ff <= {tog_sync_ff[1:0], scl_tog_ff};
      if (tog_sync_ff[1] == tog_sync_ff[2]) begin
        tog_seen_ff <= tog_sync_ff[2];
      end
    end
  end

  // ------------------------------------------------------------------
  // bus events: start, stop, falling clock, received bit
  // ------------------------------------------------------------------
  logic     scl_prev_ff;
  logic     sda_prev_ff;
  logic     tog_prev_ff;
  bus_evt_t evt;

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      tog_prev_ff <= 1'b0;
    end else begin
      scl_prev_ff <= pin_q[`PIN_SCL];
      sda_prev_ff <= pin_q[`PIN_SDA];
      tog_prev_ff <= tog_seen_ff;
    end
  end

  // data may only change while the clock is low, so an edge on the
  // data line while the clock is high marks a frame boundary
  always_comb begin
    evt.start    = pin_q[`PIN_SCL] & scl_prev_ff
                   & sda_prev_ff & ~pin_q[`PIN_SDA];
    evt.stop     = pin_q[`PIN_SCL] & scl_prev_ff
                   & ~sda_prev_ff & pin_q[`PIN_SDA];
    evt.scl_fall = scl_prev_ff & ~pin_q[`PIN_SCL];
    evt.bit_rise = tog_prev_ff ^ tog_seen_ff;
    evt.bit_val  = scl_bit_ff;
  end

  // ------------------------------------------------------------------
  // strap capture: address and variant frozen shortly after reset
  // ------------------------------------------------------------------
  logic [2:0] settle_ff;
  logic [2:0] strap_ff;
  logic       pmbus_ff;
  logic [6:0] own_addr;

  // the strap resistor is only meaningful once the filters have settled
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      settle_ff <= 3'h0;
      strap_ff  <= 3'h0;
      pmbus_ff  <= 1'b0;
    end else if (settle_ff != `STRAP_SETTLE) begin
      settle_ff <= settle_ff + 3'h1;
      strap_ff  <= pin_q[`PIN_STRAP_LO +: `ADDR_STRAP_W];
      pmbus_ff  <= pin_q[`PIN_VARIANT];
    end
  end

  // open strap reads all ones (2Fh), short reads zero (28h)
  assign own_addr = `ADDR_BASE | {4'h0, strap_ff};

  // ------------------------------------------------------------------
  // live status byte, shared by both variants
  // ------------------------------------------------------------------
  logic [7:0] live_status;

  // present pin levels, nothing latched; reserved bits tie low
  always_comb begin
    live_status                   = 8'h00;
    live_status[`ST_ENABLE_A]     = pin_q[`PIN_EN_A];
    live_status[`ST_ENABLE_B]     = pin_q[`PIN_EN_B];
    live_status[`ST_ALARM]        = pin_q[`PIN_ALARM];
    live_status[`ST_CAP_SWITCH]   = pin_q[`PIN_CAP_SW];
    live_status[`ST_INRUSH]       = pin_q[`PIN_INRUSH];
    live_status[`ST_OUT_ABOVE_UV] = pin_q[`PIN_OUT_UV];
  end

  // ------------------------------------------------------------------
  // read data lookup
  // ------------------------------------------------------------------
  logic [7:0] ptr_ff;
  logic [7:0] idx_ff;
  logic       cml_ff;
  logic [7:0] rd_data;
  logic [7:0] vin_max;
  logic [7:0] word_lo;
  logic       is_word;
  localparam logic [15:0] coef_m = `COEF_M;
  localparam logic [15:0] coef_b = `COEF_B;

  // input voltage reports the higher of the two feeds
  assign vin_max = (MEAS.feed_a_v > MEAS.feed_b_v) ? MEAS.feed_a_v
                                                   : MEAS.feed_b_v;

  // measurement words: raw count in the low byte, high byte zero
  always_comb begin
    is_word = 1'b1;
    case (ptr_ff)
      `CMD_READ_VIN:    word_lo = vin_max;
      `CMD_READ_VCAP:   word_lo = MEAS.cap_switch_on_v;
      `CMD_READ_IOUT:   word_lo = MEAS.out_current;
      `CMD_READ_TEMP:   word_lo = MEAS.temperature;
      `CMD_READ_FEED_A: word_lo = MEAS.feed_a_v;
      `CMD_READ_FEED_B: word_lo = MEAS.feed_b_v;
      default: begin
        is_word = 1'b0;
        word_lo = 8'h00;
      end
    endcase
  end

  always_comb begin
    rd_data = `UNMAPPED_DATA;
    if (pmbus_ff) begin
      if (is_word) begin
        // little-endian direct-format word
        rd_data = (idx_ff == 8'h00) ? word_lo : 8'h00;
      end else begin
        case (ptr_ff)
          `CMD_STATUS_BYTE: begin
            if (idx_ff == 8'h00) begin
              rd_data = {6'h00, cml_ff, 1'b0};
            end
          end
          `CMD_VENDOR_STAT: begin
            if (idx_ff == 8'h00) begin
              rd_data = live_status;
            end
          end
          `CMD_REVISION: begin
            if (idx_ff == 8'h00) begin
              rd_data = `REVISION_CODE;
            end
          end
          `CMD_COEFFICIENTS: begin
            // block answer: count, m, b, R
            case (idx_ff)
              8'h00:   rd_data = `COEF_COUNT;
              8'h01:   rd_data = coef_m[7:0];
              8'h02:   rd_data = coef_m[15:8];
              8'h03:   rd_data = coef_b[7:0];
              8'h04:   rd_data = coef_b[15:8];
              8'h05:   rd_data = `COEF_R;
              default: rd_data = `UNMAPPED_DATA;
            endcase
          end
          default: rd_data = `UNMAPPED_DATA;
        endcase
      end
    end else begin
      case (ptr_ff)
        `PTR_LIVE_STATUS: rd_data = live_status;
        `PTR_CAP_SWITCH_ON_V:    rd_data = MEAS.cap_switch_on_v;
        `PTR_OUT_CURRENT: rd_data = MEAS.out_current;
        `PTR_FEED_A_V:    rd_data = MEAS.feed_a_v;
        `PTR_FEED_B_V:    rd_data = MEAS.feed_b_v;
        `PTR_TEMPERATURE: rd_data = MEAS.temperature;
        default:          rd_data = `UNMAPPED_DATA;
      endcase
    end
  end

  // command codes the power-management variant accepts
  function automatic logic cmd_known(input logic [7:0] cmd);
    case (cmd)
      `CMD_CLEAR_FAULTS, `CMD_COEFFICIENTS, `CMD_STATUS_BYTE,
      `CMD_READ_VIN, `CMD_READ_VCAP, `CMD_READ_IOUT, `CMD_READ_TEMP,
      `CMD_REVISION, `CMD_READ_FEED_A, `CMD_READ_FEED_B,
      `CMD_VENDOR_STAT: cmd_known = 1'b1;
      default:          cmd_known = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // transfer state machine
  // ------------------------------------------------------------------
  xfer_state_t state_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  tx_ff;
  logic        ack_ff;
  logic        first_ff;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        ack_rise;
  logic        cml_set;
  logic        cml_clr;

  assign rx_byte   = {shift_ff[6:0], evt.bit_val};
  assign byte_done = evt.bit_rise && (cnt_ff == 4'h7);
  assign ack_rise  = evt.bit_rise && (cnt_ff == 4'h8);

  // frame phase and bit counting; the ninth rise is the ack slot
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
      shift_ff <= 8'h00;
      ack_ff   <= 1'b0;
      first_ff <= 1'b0;
    end else if (evt.start) begin
      // a repeated start simply opens a fresh address phase
      state_ff <= ST_ADDR;
      cnt_ff   <= 4'h0;
      first_ff <= 1'b1;
    end else if (evt.stop) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
    end else if (state_ff != ST_IDLE) begin
      if (evt.bit_rise) begin
        cnt_ff   <= cnt_ff + 4'h1;
        shift_ff <= rx_byte;
      end else if (evt.scl_fall && cnt_ff == 4'h9) begin
        cnt_ff <= 4'h0;
      end
      if (byte_done) begin
        case (state_ff)
          ST_ADDR: begin
            ack_ff <= (rx_byte[7:1] == own_addr);
            if (rx_byte[7:1] != own_addr) begin
              state_ff <= ST_IDLE;
            end
          end
          ST_WRITE: begin
            ack_ff   <= 1'b1;
            first_ff <= 1'b0;
          end
          default: ack_ff <= 1'b0;
        endcase
      end
      if (ack_rise) begin
        case (state_ff)
          ST_ADDR:  state_ff <= shift_ff[0] ? ST_READ : ST_WRITE;
          // host nack ends the read; release and wait for stop
          ST_READ:  state_ff <= evt.bit_val ? ST_IDLE : ST_READ;
          default:  state_ff <= state_ff;
        endcase
      end
    end
  end

  // pointer and command: written; plain pointer advanced by extra bytes and reads, PMBus index by reads only
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      ptr_ff <= `PTR_RESET;
      idx_ff <= 8'h00;
    end else if (byte_done && state_ff == ST_WRITE) begin
      if (first_ff) begin
        ptr_ff <= rx_byte;
        idx_ff <= 8'h00;
      end else if (!pmbus_ff && ptr_ff != `PTR_MAX) begin
        ptr_ff <= ptr_ff + 8'h01;
      end
    end else if (ack_rise && state_ff == ST_READ) begin
      // each byte read moves on, stopping at the top
      if (pmbus_ff) begin
        if (idx_ff != 8'hff) begin
          idx_ff <= idx_ff + 8'h01;
        end
      end else if (ptr_ff != `PTR_MAX) begin
        ptr_ff <= ptr_ff + 8'h01;
      end
    end
  end

  // fault flag: unknown command or stray data sets it, clear-faults
  // clears it; a set in the clearing cycle wins
  always_comb begin
    cml_set = 1'b0;
    cml_clr = 1'b0;
    if (pmbus_ff && byte_done && state_ff == ST_WRITE) begin
      if (first_ff) begin
        cml_set = ~cmd_known(rx_byte);
        cml_clr = (rx_byte == `CMD_CLEAR_FAULTS);
      end else begin
        cml_set = (ptr_ff != `CMD_COEFFICIENTS);
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      cml_ff <= 1'b0;
    end else begin
      cml_ff <= cml_set | (cml_ff & ~cml_clr);
    end
  end

  // ------------------------------------------------------------------
  // data line driver: changes only just after the clock falls
  // ------------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      SDA_OE_N <= 1'b1;
      tx_ff    <= 8'h00;
    end else if (evt.start || evt.stop || state_ff == ST_IDLE) begin
      SDA_OE_N <= 1'b1;
    end else if (evt.scl_fall) begin
      if (cnt_ff == 4'h8) begin
        // ack slot: pull low for our acks, let go for the host's
        SDA_OE_N <= ~(ack_ff && state_ff != ST_READ);
      end else if (cnt_ff == 4'h9) begin
        if (state_ff == ST_READ) begin
          tx_ff    <= rd_data;
          SDA_OE_N <= rd_data[7];
        end else begin
          SDA_OE_N <= 1'b1;
        end
      end else if (state_ff == ST_READ) begin
        SDA_OE_N <= tx_ff[3'h7 - cnt_ff[2:0]];
      end
    end
  end

  // the line is only ever pulled low; a high bit is a released line
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      SDA_OUT   <= 1'b0;
      CML_FAULT <= 1'b0;
    end else begin
      SDA_OUT   <= 1'b0;
      CML_FAULT <= cml_ff;
    end
  end

endmodule // monitor_serial_slave

/* File: test/serial_host_model.sv */
// Purpose: bit-level two-wire host for the monitor serial bench
// Assumes: open-drain SDA is resolved by the bench, pulled up
// Notes:   SCL stands high between frames; no clock stretching
`timescale 1ns/1ps

module serial_host_model (
  // bus pins
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  localparam realtime QTR = 31.25;

  // idle bus: both lines released high
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // short clock pulse while the target is held in reset, so the
  // link-domain flops take their reset values
  task automatic reset_edge();
    scl = 1'b0;
    #2 scl = 1'b1;
  endtask

  // one bit slot: data moves while SCL is low, sampled mid-high
  task automatic bit_slot(input logic b, output logic s);
    sda_drv = b;
    #QTR scl = 1'b1;
    #QTR s = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  // start, or repeated start from a low clock
  task automatic start_cond();
    sda_drv = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b0;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  // stop leaves both lines released, clock parked high
  task automatic stop_cond();
    sda_drv = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b1;
    #QTR;
  endtask

  // byte out msb first, then the target's ack slot
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask

  // byte in msb first; nack ends the read
  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(nack, s);
  endtask

  // host-side scaling of raw counts, kept for readability of logs
  function automatic real volts(input logic [7:0] c, input real k);
    return c * k;
  endfunction
  function automatic real deg_c(input logic [7:0] c);
    return c * 1.961 - 50.0;
  endfunction
endmodule // serial_host_model

/* File: test/monitor_serial_checker.sv */
// Purpose: bus-side assertions for the monitor serial target
// Assumes: sees only the top module ports
// Notes:   host holds SCL high only briefly inside frames
`timescale 1ns/1ps

module monitor_serial_checker
  import monitor_serial_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       RSTN,
  input wire logic       SCL,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE_N,
  input wire logic [2:0] ADDR_STRAP,
  input wire logic       PMBUS_SEL,
  input wire logic       ENABLE_A,
  input wire logic       ENABLE_B,
  input wire logic       FEED_ALARM,
  input wire logic       CAP_SWITCH_ON,
  input wire logic       INRUSH_SWITCH_ON,
  input wire logic       OUT_ABOVE_UV,
  input wire meas_t      MEAS,
  input wire logic       CML_FAULT
);
  logic [5:0] scl_hi_ff;
  logic [7:0] drv_ff;

  // cycles with SCL high; a long run means the bus is parked
  always_ff @(posedge REF_CLK) begin
    if (!RSTN || !SCL) scl_hi_ff <= 6'h00;
    else if (scl_hi_ff != 6'h3f) scl_hi_ff <= scl_hi_ff + 6'h01;
  end

  // cycles the target has held SDA low without a break
  always_ff @(posedge REF_CLK) begin
    if (!RSTN || SDA_OE_N) drv_ff <= 8'h00;
    else if (drv_ff != 8'hff) drv_ff <= drv_ff + 8'h01;
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  a_reset_quiet: assert property ($rose(RSTN) |-> SDA_OE_N && !CML_FAULT)
    else $error("outputs busy right after reset");
  a_drive_low_only: assert property (SDA_OUT == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL && !$past(SCL))
    else $error("data drive changed while clock high");
  a_drive_bounded: assert property (drv_ff < 8'hc8)
    else $error("data line held low too long");
  a_idle_release: assert property (scl_hi_ff > 6'h14 |-> SDA_OE_N)
    else $error("data line held on a parked bus");
  a_plain_no_cml: assert property (!PMBUS_SEL |-> !CML_FAULT)
    else $error("fault flag set in plain variant");
  a_cml_rise_pm: assert property ($rose(CML_FAULT) |-> PMBUS_SEL && scl_hi_ff < 6'h14)
    else $error("fault flag rose outside a transfer");
  a_cml_fall_busy: assert property ($fell(CML_FAULT) |-> scl_hi_ff < 6'h14)
    else $error("fault flag cleared outside a transfer");
endmodule // monitor_serial_checker

bind monitor_serial_slave monitor_serial_checker u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .SCL(SCL), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .ADDR_STRAP(ADDR_STRAP),
  .PMBUS_SEL(PMBUS_SEL), .ENABLE_A(ENABLE_A), .ENABLE_B(ENABLE_B),
  .FEED_ALARM(FEED_ALARM), .CAP_SWITCH_ON(CAP_SWITCH_ON),
  .INRUSH_SWITCH_ON(INRUSH_SWITCH_ON), .OUT_ABOVE_UV(OUT_ABOVE_UV),
  .MEAS(MEAS), .CML_FAULT(CML_FAULT)
);

/* File: test/monitor_serial_slave_tb_top.sv */
// Purpose: self-checking bench for the monitor serial target
// Assumes: host model makes SCL at 125 ns only inside frames
// Notes:   plain variant first, then a mid-run reset into PMBus
`timescale 1ns/1ps
`include "monitor_serial_params.svh"

module monitor_serial_slave_tb_top
  import monitor_serial_pkg::*;
;
  typedef struct packed {
    logic       pm;
    logic [7:0] cmd;
    logic [7:0] exp;
  } row_t;

  // measurements 5a 3c 81 7e c3, status pins give 65h
  localparam row_t ROWS [18] = '{
    '{1'b0, 8'h1e, 8'h65}, '{1'b0, 8'h1f, 8'h5a}, '{1'b0, 8'h21, 8'h3c},
    '{1'b0, 8'h22, 8'h81}, '{1'b0, 8'h23, 8'h7e}, '{1'b0, 8'h28, 8'hc3},
    '{1'b0, 8'h20, 8'h00}, '{1'b0, 8'h1d, 8'h00}, '{1'b0, 8'hff, 8'h00},
    '{1'b1, 8'h8a, 8'h5a}, '{1'b1, 8'h8c, 8'h3c}, '{1'b1, 8'h8d, 8'hc3},
    '{1'b1, 8'hd3, 8'h81}, '{1'b1, 8'hd4, 8'h7e}, '{1'b1, 8'hd5, 8'h65},
    '{1'b1, 8'h88, 8'h81}, '{1'b1, 8'h78, 8'h00}, '{1'b1, 8'h98, 8'h22}};

  logic        ref_clk, rstn, pm_sel, cml, sda_out, sda_oe_n;
  logic        en_a, en_b, alarm, cap_sw, inrush, uv, a;
  logic [2:0]  strap;
  logic [6:0]  dev_addr;
  logic [15:0] cm, cb;
  logic [7:0]  rx [6];
  logic [7:0]  coef [6];
  meas_t       meas;
  wire  logic  scl, sda_drv, sda;
  int          fails, n_tests;

  // open-drain data wire, pulled up when nobody drives
  assign sda = sda_drv & (sda_oe_n | sda_out);

  serial_host_model host (.scl(scl), .sda_drv(sda_drv), .sda(sda));

  monitor_serial_slave dut (
    .REF_CLK(ref_clk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDR_STRAP(strap),
    .PMBUS_SEL(pm_sel), .ENABLE_A(en_a), .ENABLE_B(en_b),
    .FEED_ALARM(alarm), .CAP_SWITCH_ON(cap_sw), .INRUSH_SWITCH_ON(inrush),
    .OUT_ABOVE_UV(uv), .MEAS(meas), .CML_FAULT(cml));

  // system clock, 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // pointer or command write; no stop leaves room for a repeated start
  task automatic set_ptr(input logic [7:0] p, input logic stop);
    host.start_cond();
    host.write_byte({dev_addr, 1'b0}, a);
    check({7'h00, a}, 8'h01);
    host.write_byte(p, a);
    check({7'h00, a}, 8'h01);
    if (stop) host.stop_cond();
  endtask

  // read n bytes, nack on the last
  task automatic rd(input int n);
    host.start_cond();
    host.write_byte({dev_addr, 1'b1}, a);
    check({7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) host.read_byte(i == n - 1, rx[i]);
    host.stop_cond();
  endtask

  task automatic pins(input logic [5:0] v);
    @(negedge ref_clk);
    {uv, inrush, cap_sw, alarm, en_b, en_a} = v;
  endtask

  task automatic do_reset(input logic pm);
    @(negedge ref_clk);
    rstn   = 1'b0;
    pm_sel = pm;
    host.reset_edge(); // link flops reset only on a serial clock edge
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (12) @(negedge ref_clk);
  endtask

  // a hang ends the run through the same report
  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    final_report();
  end

  initial begin
    fails    = 0;
    n_tests  = 0;
    rstn     = 1'b0;
    pm_sel   = 1'b0;
    strap    = 3'h5;
    meas     = {8'h5a, 8'h3c, 8'h81, 8'h7e, 8'hc3};
    {uv, inrush, cap_sw, alarm, en_b, en_a} = 6'h35;
    dev_addr = `ADDR_BASE | {4'h0, strap};
    do_reset(1'b0);
    foreach (ROWS[i]) if (ROWS[i].pm == 1'b0) begin
      set_ptr(ROWS[i].cmd, 1'b0);
      rd(1);
      check(rx[0], ROWS[i].exp);
    end
    // a neighbour address must get no ack
    host.start_cond();
    host.write_byte({dev_addr ^ 7'h01, 1'b0}, a);
    host.stop_cond();
    check({7'h00, a}, 8'h00);
    set_ptr(8'h21, 1'b0);
    rd(3);
    check(rx[0], 8'h3c);
    check(rx[2], 8'h7e);
    // two dropped data bytes still move the pointer 1Fh to 21h
    set_ptr(8'h1f, 1'b0);
    host.write_byte(8'ha5, a);
    host.write_byte(8'h5a, a);
    host.stop_cond();
    rd(1);
    check(rx[0], 8'h3c);
    // status follows the pins, polled again and again
    pins(6'h0a);
    set_ptr(8'h1e, 1'b1);
    rd(2);
    check(rx[0], 8'h12);
    check(rx[1], 8'h5a);
    pins(6'h3f);
    set_ptr(8'h1e, 1'b1);
    rd(1);
    check(rx[0], 8'h77);
    pins(6'h35);
    do_reset(1'b1);
    check({7'h00, cml}, 8'h00);
    foreach (ROWS[i]) if (ROWS[i].pm == 1'b1) begin
      set_ptr(ROWS[i].cmd, 1'b0);
      rd(1);
      check(rx[0], ROWS[i].exp);
    end
    set_ptr(8'h8a, 1'b0);
    rd(2);
    check(rx[1], 8'h00);
    cm   = `COEF_M;
    cb   = `COEF_B;
    coef = '{`COEF_COUNT, cm[7:0], cm[15:8], cb[7:0], cb[15:8], `COEF_R};
    set_ptr(8'h30, 1'b0);
    rd(6);
    foreach (coef[i]) check(rx[i], coef[i]);
    // unknown command raises the fault; clear drops only that bit
    set_ptr(8'h99, 1'b1);
    repeat (10) @(negedge ref_clk);
    check({7'h00, cml}, 8'h01);
    set_ptr(8'h78, 1'b0);
    rd(1);
    check(rx[0], 8'h02);
    set_ptr(8'h03, 1'b1);
    repeat (10) @(negedge ref_clk);
    check({7'h00, cml}, 8'h00);
    set_ptr(8'hd5, 1'b0);
    rd(1);
    check(rx[0], 8'h65);
    set_ptr(8'h78, 1'b0);
    rd(1);
    check(rx[0], 8'h00);
    final_report();
  end
endmodule // monitor_serial_slave_tb_top
